// File: ucf_pkg.sv
package ucf_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 4;
    localparam int GATE_MIN_NS      = 100000;
    localparam int GATE_BASE_CYCLES = GATE_MIN_NS / CLK_PERIOD_NS;
    localparam int TACH_GATE_NS     = 600000000;
    localparam int TACH_GATE_TICKS  = TACH_GATE_NS / GATE_MIN_NS;
    localparam int DEAD_TIME_NS     = 4000;
    localparam int DEAD_CYCLES      = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LSD_MIN_NS       = 10;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int          DISPLAY_DIGITS = 8;
    localparam int          RES_STEPS      = 6;
    localparam logic [2:0]  RES_MAX        = 3'h5;
    localparam logic [31:0] RESULT_RESET   = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Function codes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        FN_FIRST_INPUT_FREQUENCY = 3'h0,
        FN_TACHOMETER_COUNT      = 3'h1,
        FN_HIGH_BAND_FREQUENCY   = 3'h2,
        FN_QUOTIENT              = 3'h3,
        FN_SINGLE_PERIOD         = 3'h4,
        FN_AVERAGED_PERIOD       = 3'h5,
        FN_START_STOP_INTERVAL   = 3'h6
    } ucf_func_t;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ARM  = 4'h2,
        ST_GATE = 4'h4,
        ST_DONE = 4'h8
    } ucf_state_t;

endpackage : ucf_pkg

// File: ucf_bcd_accum.sv
`timescale 1ns/1ps
`default_nettype none

module ucf_bcd_accum
    import ucf_pkg::*;
#(
    parameter int DIGITS = DISPLAY_DIGITS
) (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  reset,
    // Control
    input  wire logic                  clear,
    input  wire logic                  inc,
    // State
    output logic [4*DIGITS-1:0]        value_reg,
    output logic                       overflow_reg
);

    initial begin
        if (DIGITS < 1) begin
            $error("ucf_bcd_accum: DIGITS must be at least 1");
        end
    end

    logic [4*DIGITS-1:0] value_next;
    logic                overflow_next;
    logic                carry;

    // ------------------------------------------------------------------
    // Decimal ripple increment
    // ------------------------------------------------------------------
    always_comb begin
        value_next    = value_reg;
        overflow_next = overflow_reg;
        carry         = inc;
        if (clear) begin
            value_next    = '0;
            overflow_next = 1'b0;
        end else begin
            for (int d = 0; d < DIGITS; d++) begin
                if (carry) begin
                    if (value_reg[4*d +: 4] == 4'h9) begin
                        value_next[4*d +: 4] = 4'h0;
                    end else begin
                        value_next[4*d +: 4] = value_reg[4*d +: 4] + 4'h1;
                        carry                = 1'b0;
                    end
                end
            end
            if (carry) begin
                overflow_next = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            value_reg    <= '0;
            overflow_reg <= 1'b0;
        end else begin
            value_reg    <= value_next;
            overflow_reg <= overflow_next;
        end
    end

endmodule : ucf_bcd_accum

`default_nettype wire

// File: ucf_sequencer.sv
// Summary of operation
// - Frequency gate is 0.1 ms times ten to the resolution step, up to 10 s.
// - First-input frequency counts input edges straight into the display count.
// - Overflow indicator lights when the count passes display capacity.
// - Tachometer gate fixed at 0.6 s; no decimal point, no unit.
// - Optional third input counted over the resolution gate when fitted.
// - Quotient counts first input per second-input gate, shown without unit.
// - Quotient gate opens and closes on second-input events.
// - Single period times from one first-input edge to the next.
// - Single period digit weight is 10 ns up to 1 ms by resolution.
// - Averaged period times ten to the step periods at 10 ns weight.
// - Averaged period serves first-input rates from 5 Hz to 1 MHz.
// - Interval starts on first input and stops on a later stop event.
// - Stop events within 4 us of the start are ignored.
// - Common sharing feeds the first input to the stop path too.
// - Gate indicator is high while counting or timing runs.
// - Accumulator holds eight decades and flags overflow beyond them.
// - Free run restarts a measurement after each one completes.
`timescale 1ns/1ps
`default_nettype none

module ucf_sequencer
    import ucf_pkg::*;
#(
    parameter int unsigned GATE_BASE = GATE_BASE_CYCLES,
    parameter bit          HIGH_BAND_FITTED = 1'b1
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              reset,
    // Conditioned pulse inputs
    input  wire logic              first_input,
    input  wire logic              second_input,
    input  wire logic              third_input,
    // Front panel selectors
    input  wire logic [2:0]        meas_function,
    input  wire logic [2:0]        resolution,
    input  wire logic              input_sharing_select,
    input  wire logic              free_run,
    input  wire logic              measure_request,
    // Display
    output logic [31:0]            result_reg,
    output logic                   result_valid_reg,
    output logic                   overflow_indicator_reg,
    output logic                   gate_indicator_reg,
    output logic                   dp_enable_reg,
    output logic [2:0]             dp_select_reg,
    output logic                   unit_enable_reg
);

    initial begin
        if (GATE_BASE < 1) begin
            $error("ucf_sequencer: GATE_BASE must be at least 1");
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] pow10(input logic [2:0] r);
        case (r)
            3'h0:    pow10 = 32'h0000_0001;
            3'h1:    pow10 = 32'h0000_000a;
            3'h2:    pow10 = 32'h0000_0064;
            3'h3:    pow10 = 32'h0000_03e8;
            3'h4:    pow10 = 32'h0000_2710;
            default: pow10 = 32'h0001_86a0;
        endcase
    endfunction : pow10

    function automatic logic is_timed(input logic [2:0] f);
        is_timed = (f == FN_FIRST_INPUT_FREQUENCY) || (f == FN_TACHOMETER_COUNT)
                   || (f == FN_HIGH_BAND_FREQUENCY);
    endfunction : is_timed

    // ------------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------------
    logic a_prev_reg, b_prev_reg, c_prev_reg;
    logic a_edge, b_edge, c_edge, stop_edge;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            a_prev_reg <= 1'b0;
            b_prev_reg <= 1'b0;
            c_prev_reg <= 1'b0;
        end else begin
            a_prev_reg <= first_input;
            b_prev_reg <= second_input;
            c_prev_reg <= third_input;
        end
    end

    assign a_edge    = first_input & ~a_prev_reg;
    assign b_edge    = second_input & ~b_prev_reg;
    assign c_edge    = third_input & ~c_prev_reg;
    assign stop_edge = input_sharing_select ? a_edge : b_edge;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    ucf_state_t  state_reg, state_next;
    logic [2:0]  func_reg, func_next;
    logic [2:0]  res_reg, res_next;
    logic [31:0] base_reg, base_next;
    logic [31:0] gate_cnt_reg, gate_cnt_next;
    logic [19:0] phase_reg, phase_next;
    logic [9:0]  dead_reg, dead_next;
    logic [31:0] result_next;
    logic        valid_next, ovf_next, gate_next, dp_en_next, unit_next;
    logic [2:0]  dp_sel_next;
    logic [31:0] target;
    logic [19:0] weight;
    logic [19:0] phase_sum;
    logic        base_tick, time_tick, acc_clear, acc_inc, close;
    logic [31:0] acc_value;
    logic        acc_ovf;

    always_comb begin
        state_next    = state_reg;
        func_next     = func_reg;
        res_next      = res_reg;
        base_next     = base_reg;
        gate_cnt_next = gate_cnt_reg;
        phase_next    = phase_reg;
        dead_next     = dead_reg;
        result_next   = result_reg;
        ovf_next      = overflow_indicator_reg;
        dp_en_next    = dp_enable_reg;
        dp_sel_next   = dp_select_reg;
        unit_next     = unit_enable_reg;
        valid_next    = 1'b0;
        acc_clear     = 1'b0;
        acc_inc       = 1'b0;
        close         = 1'b0;
        base_tick     = 1'b0;
        time_tick     = 1'b0;
        phase_sum     = phase_reg + 20'h4;

        case (func_reg)
            FN_TACHOMETER_COUNT: target = 32'(TACH_GATE_TICKS);
            FN_SINGLE_PERIOD:    target = 32'h0000_0001;
            default:             target = pow10(res_reg);
        endcase
        if (func_reg == FN_AVERAGED_PERIOD) begin
            weight = 20'(LSD_MIN_NS);
        end else begin
            weight = 20'(pow10(res_reg) * 32'(LSD_MIN_NS));
        end

        case (state_reg)
            ST_IDLE: begin
                if ((free_run || measure_request) &&
                    (HIGH_BAND_FITTED || meas_function != FN_HIGH_BAND_FREQUENCY)) begin
                    func_next  = meas_function;
                    res_next   = (resolution > RES_MAX) ? RES_MAX : resolution;
                    acc_clear  = 1'b1;
                    state_next = ST_ARM;
                end
            end
            ST_ARM: begin
                base_next     = '0;
                gate_cnt_next = '0;
                phase_next    = '0;
                dead_next     = 10'(DEAD_CYCLES);
                if (is_timed(func_reg) ||
                    (func_reg == FN_QUOTIENT && b_edge) ||
                    (func_reg != FN_QUOTIENT && a_edge)) begin
                    state_next = ST_GATE;
                end
            end
            ST_GATE: begin
                // Reference-derived ticks
                if (base_reg == 32'(GATE_BASE - 1)) begin
                    base_next = '0;
                    base_tick = 1'b1;
                end else begin
                    base_next = base_reg + 32'h1;
                end
                if (phase_sum >= weight) begin
                    phase_next = phase_sum - weight;
                    time_tick  = 1'b1;
                end else begin
                    phase_next = phase_sum;
                end
                if (dead_reg != 10'h0) begin
                    dead_next = dead_reg - 10'h1;
                end
                case (func_reg)
                    FN_FIRST_INPUT_FREQUENCY, FN_TACHOMETER_COUNT: begin
                        acc_inc = a_edge;
                        close   = base_tick && (gate_cnt_reg + 32'h1 == target);
                        if (base_tick) gate_cnt_next = gate_cnt_reg + 32'h1;
                    end
                    FN_HIGH_BAND_FREQUENCY: begin
                        acc_inc = c_edge;
                        close   = base_tick && (gate_cnt_reg + 32'h1 == target);
                        if (base_tick) gate_cnt_next = gate_cnt_reg + 32'h1;
                    end
                    FN_QUOTIENT: begin
                        acc_inc = a_edge;
                        close   = b_edge && (gate_cnt_reg + 32'h1 == target);
                        if (b_edge) gate_cnt_next = gate_cnt_reg + 32'h1;
                    end
                    FN_START_STOP_INTERVAL: begin
                        acc_inc = time_tick;
                        close   = stop_edge && (dead_reg == 10'h0);
                    end
                    default: begin
                        acc_inc = time_tick;
                        close   = a_edge && (gate_cnt_reg + 32'h1 == target);
                        if (a_edge) gate_cnt_next = gate_cnt_reg + 32'h1;
                    end
                endcase
                if (close) begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                result_next = acc_value;
                ovf_next    = acc_ovf;
                valid_next  = 1'b1;
                dp_en_next  = (func_reg != FN_TACHOMETER_COUNT);
                unit_next   = (func_reg != FN_TACHOMETER_COUNT) &&
                              (func_reg != FN_QUOTIENT);
                dp_sel_next = res_reg;
                state_next  = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        gate_next = (state_next == ST_GATE);
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_reg              <= ST_IDLE;
            func_reg               <= FN_FIRST_INPUT_FREQUENCY;
            res_reg                <= 3'h0;
            base_reg               <= '0;
            gate_cnt_reg           <= '0;
            phase_reg              <= '0;
            dead_reg               <= '0;
            result_reg             <= RESULT_RESET;
            result_valid_reg       <= 1'b0;
            overflow_indicator_reg <= 1'b0;
            gate_indicator_reg     <= 1'b0;
            dp_enable_reg          <= 1'b0;
            dp_select_reg          <= 3'h0;
            unit_enable_reg        <= 1'b0;
        end else begin
            state_reg              <= state_next;
            func_reg               <= func_next;
            res_reg                <= res_next;
            base_reg               <= base_next;
            gate_cnt_reg           <= gate_cnt_next;
            phase_reg              <= phase_next;
            dead_reg               <= dead_next;
            result_reg             <= result_next;
            result_valid_reg       <= valid_next;
            overflow_indicator_reg <= ovf_next;
            gate_indicator_reg     <= gate_next;
            dp_enable_reg          <= dp_en_next;
            dp_select_reg          <= dp_sel_next;
            unit_enable_reg        <= unit_next;
        end
    end

    // ------------------------------------------------------------------
    // Eight-decade accumulator
    // ------------------------------------------------------------------
    ucf_bcd_accum #(
        .DIGITS       (DISPLAY_DIGITS)
    ) u_accum (
        .sys_clk      (sys_clk),
        .reset        (reset),
        .clear        (acc_clear),
        .inc          (acc_inc),
        .value_reg    (acc_value),
        .overflow_reg (acc_ovf)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [31:0] gate_len_reg;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            gate_len_reg <= '0;
        end else begin
            gate_len_reg <= (state_reg == ST_GATE) ? gate_len_reg + 32'h1 : '0;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    a_gate_tracks_state: assert property (
        gate_indicator_reg == (state_reg == ST_GATE))
        else $error("gate indicator disagrees with sequencer");
    a_freq_gate_len: assert property (
        (state_reg == ST_DONE && func_reg == FN_FIRST_INPUT_FREQUENCY)
        |-> gate_len_reg == pow10(res_reg) * GATE_BASE)
        else $error("frequency gate length wrong");
    a_tach_gate_len: assert property (
        (state_reg == ST_DONE && func_reg == FN_TACHOMETER_COUNT)
        |-> gate_len_reg == 32'(TACH_GATE_TICKS) * GATE_BASE)
        else $error("tachometer gate length wrong");
    a_dead_stop_ignored: assert property (
        (state_reg == ST_GATE && func_reg == FN_START_STOP_INTERVAL && dead_reg != 10'h0)
        |=> state_reg == ST_GATE)
        else $error("stop taken inside dead time");
    a_common_stop_route: assert property (
        (state_reg == ST_GATE && func_reg == FN_START_STOP_INTERVAL && dead_reg == 10'h0
         && input_sharing_select && a_edge) |=> state_reg == ST_DONE)
        else $error("common stop not routed from first input");
    a_quot_gate_open: assert property (
        (state_reg == ST_ARM && func_reg == FN_QUOTIENT && !b_edge) |=> state_reg == ST_ARM)
        else $error("quotient gate opened without second input");
    a_period_start: assert property (
        (state_reg == ST_ARM && func_reg == FN_SINGLE_PERIOD && a_edge)
        |=> state_reg == ST_GATE ##1 gate_indicator_reg)
        else $error("period did not start on first input");
    a_result_overflow: assert property (
        (state_reg == ST_DONE) |=> result_valid_reg && overflow_indicator_reg == $past(acc_ovf)
        && result_reg == $past(acc_value))
        else $error("result or overflow not latched");
    a_no_unit_shown: assert property (
        (result_valid_reg && (func_reg == FN_QUOTIENT || func_reg == FN_TACHOMETER_COUNT))
        |-> !unit_enable_reg)
        else $error("unit shown where none allowed");
    a_free_run_restart: assert property (
        (state_reg == ST_IDLE && free_run && meas_function != FN_HIGH_BAND_FREQUENCY)
        |=> state_reg == ST_ARM)
        else $error("free run did not restart");

    c_freq_done: cover property (state_reg == ST_DONE && func_reg == FN_FIRST_INPUT_FREQUENCY);
    c_interval_done: cover property (state_reg == ST_DONE && func_reg == FN_START_STOP_INTERVAL);
    c_quotient_done: cover property (state_reg == ST_DONE && func_reg == FN_QUOTIENT);
    c_overflow_seen: cover property (result_valid_reg && overflow_indicator_reg);

endmodule : ucf_sequencer

`default_nettype wire

// File: ucf_pulse_src.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Pulse sources for the three conditioned inputs
// ------------------------------------------------------------------
module ucf_pulse_src (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset,
    // Channel setup, half period in clocks per channel
    input  wire logic [2:0]  en,
    input  wire logic [47:0] half,
    // Pulse outputs, low while disabled
    output logic      [2:0]  pulse
);
    logic [15:0] cnt_reg [3];

    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < 3; i++) begin
            if (reset || !en[i]) begin
                cnt_reg[i] <= 16'h0000;
                pulse[i]   <= 1'b0;
            end else if (cnt_reg[i] >= half[16*i+:16] - 16'h0001) begin
                cnt_reg[i] <= 16'h0000;
                pulse[i]   <= ~pulse[i];
            end else begin
                cnt_reg[i] <= cnt_reg[i] + 16'h0001;
            end
        end
    end
endmodule : ucf_pulse_src

`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import ucf_pkg::*;
    localparam int G = 4;
    logic        sys_clk, reset, input_sharing_select, free_run, measure_request;
    logic [2:0]  meas_function, resolution, en, pulse, dp_select_reg;
    logic [47:0] half;
    logic [31:0] result_reg;
    logic        result_valid_reg, overflow_indicator_reg, gate_indicator_reg;
    logic        dp_enable_reg, unit_enable_reg;
    int          fails, n_checks, gl, val, nv;

    // ------------------------------------------------------------------
    // Clock and instances
    // ------------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    ucf_pulse_src i_ucf_pulse_src (
        .sys_clk(sys_clk), .reset(reset), .en(en), .half(half), .pulse(pulse)
    );

    ucf_sequencer #(.GATE_BASE(G)) i_ucf_sequencer (
        .sys_clk(sys_clk), .reset(reset),
        .first_input(pulse[0]), .second_input(pulse[1]), .third_input(pulse[2]),
        .meas_function(meas_function), .resolution(resolution),
        .input_sharing_select(input_sharing_select), .free_run(free_run),
        .measure_request(measure_request), .result_reg(result_reg),
        .result_valid_reg(result_valid_reg), .overflow_indicator_reg(overflow_indicator_reg),
        .gate_indicator_reg(gate_indicator_reg), .dp_enable_reg(dp_enable_reg),
        .dp_select_reg(dp_select_reg), .unit_enable_reg(unit_enable_reg)
    );

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic stop_test;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input int lo, input int hi);
        n_checks++;
        if ($isunknown(got) || int'(got) < lo || int'(got) > hi) begin
            fails++;
            $display("[FAIL] %0t got %h want %h..%h", $time, got, lo, hi);
        end
    endtask : chk

    task automatic chkb(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask : chkb

    function automatic int bcd(input logic [31:0] r);
        int v;
        v = 0;
        if ($isunknown(r)) return -1;
        for (int i = 7; i >= 0; i--) v = v * 10 + int'(r[4*i+:4]);
        return v;
    endfunction : bcd

    // Start one measurement, time its gate and take the result
    task automatic measure(input logic [2:0] f, input logic [2:0] r);
        int k;
        repeat (2) @(posedge sys_clk);
        meas_function   <= f;
        resolution      <= r;
        measure_request <= 1'b1;
        @(posedge sys_clk);
        measure_request <= 1'b0;
        k = 0;
        while (gate_indicator_reg !== 1'b1 && k < 3000) begin
            @(negedge sys_clk);
            k++;
        end
        gl = 0;
        while (gate_indicator_reg === 1'b1 && gl < 30000) begin
            @(negedge sys_clk);
            gl++;
        end
        k = 0;
        while (result_valid_reg !== 1'b1 && k < 10) begin
            @(negedge sys_clk);
            k++;
        end
        if (result_valid_reg !== 1'b1) begin
            fails++;
            stop_test();
        end
        val = bcd(result_reg);
        @(posedge sys_clk);
    endtask : measure

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        reset = 1'b1;
        input_sharing_select = 1'b0;
        free_run = 1'b0;
        measure_request = 1'b0;
        meas_function = 3'h0;
        resolution = 3'h0;
        en = 3'h0;
        half = {16'h0001, 16'h0014, 16'h0002};
        fails = 0;
        n_checks = 0;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        en    <= 3'h1;
        for (int r = 0; r < 4; r++) begin
            measure(3'h0, r[2:0]);
            chk(gl, G * 10**r, G * 10**r);
            chk(val, G * 10**r / 4 - 1, G * 10**r / 4 + 1);
            chk(32'(dp_select_reg), r, r);
            chkb(overflow_indicator_reg, 1'b0);
            chkb(dp_enable_reg, 1'b1);
            chkb(unit_enable_reg, 1'b1);
        end
        measure(3'h1, 3'h3);
        chk(gl, 6000 * G, 6000 * G);
        chk(val, 5999, 6001);
        chkb(dp_enable_reg, 1'b0);
        chkb(unit_enable_reg, 1'b0);
        en <= 3'h5;
        measure(3'h2, 3'h1);
        chk(val, 19, 21);
        en <= 3'h3;
        measure(3'h3, 3'h1);
        chk(gl, 399, 401);
        chk(val, 99, 101);
        chkb(unit_enable_reg, 1'b0);
        en   <= 3'h1;
        half <= {16'h0001, 16'h0096, 16'h0032};
        measure(3'h4, 3'h0);
        chk(gl, 99, 101);
        chk(val, 39, 41);
        measure(3'h4, 3'h1);
        chk(val, 3, 5);
        half <= {16'h0001, 16'h0096, 16'h007d};
        measure(3'h5, 3'h1);
        chk(gl, 2499, 2501);
        chk(val, 999, 1001);
        en   <= 3'h3;
        half <= {16'h0001, 16'h0096, 16'h0190};
        measure(3'h6, 3'h0);
        chk(gl, 1000, 1300);
        chk(val, gl * 4 / 10 - 1, gl * 4 / 10 + 1);
        en   <= 3'h1;
        input_sharing_select <= 1'b1;
        half <= {16'h0001, 16'h0096, 16'h0064};
        measure(3'h6, 3'h0);
        chk(gl, 1000, 1200);
        input_sharing_select <= 1'b0;
        half <= {16'h0001, 16'h0096, 16'h0002};
        meas_function <= 3'h0;
        resolution    <= 3'h0;
        free_run      <= 1'b1;
        nv = 0;
        repeat (200) begin
            @(negedge sys_clk);
            if (result_valid_reg === 1'b1) nv++;
        end
        chk(nv, 15, 40);
        @(posedge sys_clk);
        free_run <= 1'b0;
        repeat (20) @(posedge sys_clk);
        stop_test();
    end
endmodule : testbench

`default_nettype wire
